// ===== src/rshp_pkg.sv
// Shared constants and types for the strap and host-pin block.
// Assumes a 40 MHz clock on both ends; all counts derive from it.
package rshp_pkg;
    typedef enum logic [1:0] {
        RSHP_I2C_A = 2'b00,
        RSHP_I2C_B = 2'b01,
        RSHP_SPI_SLAVE = 2'b10,
        RSHP_SPI_MASTER = 2'b11
    } rshp_mode_type;

    localparam logic [6:0] I2C_ADDR_A = 7'h74;
    localparam logic [6:0] I2C_ADDR_B = 7'h75;

    // Per-pin io field codes; any other code leaves the pin an input
    localparam logic [1:0] IO_CFG_OUT_LOW = 2'h1;
    localparam logic [1:0] IO_CFG_OUT_HIGH = 2'h2;

    // Strap capture layout
    localparam int STRAP_W = 6;
    localparam int STRAP_IF_LSB = 0;
    localparam int STRAP_AC_LSB = 2;
    localparam int STRAP_TEST_BIT = 5;
    localparam logic [2:0] AC_NO_AUTOCFG = 3'h3;

    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam logic [7:0] EE_START_ADDR = 8'h00;
    localparam int EE_HEADER_BITS = 16;

    localparam int CLOCK_PERIOD_NS = 25;
    localparam int MST_HALF_NS = 200;
    localparam int MST_HALF_CYC = (MST_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int HOST_HALF_NS = 100;
    localparam int HOST_HALF_CYC = (HOST_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int HOST_SETUP_NS = 200;
    localparam int HOST_SETUP_CYC = (HOST_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STRAP_HOLD_NS = 200;
    localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_SEND = 3'b001,
        M_READ = 3'b010,
        M_FINISH = 3'b011,
        M_DONE = 3'b100
    } rshp_mst_type;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SETUP = 2'b01,
        H_RUN = 2'b10,
        H_END = 2'b11
    } rshp_hst_type;
endpackage

// ===== src/rshp_pins_if.sv
// Shared pins between the device end and the host end.
// Every pin but global_reset_n is wired-AND with a pull-up: a driver pulls low or releases.
`timescale 1ns/1ps
interface rshp_pins_if;
    logic global_reset_n;
    logic [3:0] io_dev_out, io_dev_oe, io_host_out, io_host_oe, io;
    logic ssn_dev_out, ssn_dev_oe, ssn_host_out, ssn_host_oe, serial_select_n;
    logic miso_dev_out, miso_dev_oe, miso_host_out, miso_host_oe, miso;
    logic sclk_dev_out, sclk_dev_oe, sclk_host_out, sclk_host_oe, sclk;
    logic sda_dev_out, sda_dev_oe, sda_host_out, sda_host_oe, sda;

    assign io = ~((io_dev_oe & ~io_dev_out) | (io_host_oe & ~io_host_out));
    assign serial_select_n = ~((ssn_dev_oe & ~ssn_dev_out) | (ssn_host_oe & ~ssn_host_out));
    assign miso = ~((miso_dev_oe & ~miso_dev_out) | (miso_host_oe & ~miso_host_out));
    assign sclk = ~((sclk_dev_oe & ~sclk_dev_out) | (sclk_host_oe & ~sclk_host_out));
    assign sda = ~((sda_dev_oe & ~sda_dev_out) | (sda_host_oe & ~sda_host_out));

    modport device (
        input global_reset_n, io, serial_select_n, miso, sclk, sda,
        output io_dev_out, io_dev_oe, ssn_dev_out, ssn_dev_oe, miso_dev_out, miso_dev_oe,
        output sclk_dev_out, sclk_dev_oe, sda_dev_out, sda_dev_oe
    );
    modport host (
        input io, serial_select_n, miso, sclk, sda,
        output global_reset_n, io_host_out, io_host_oe, ssn_host_out, ssn_host_oe,
        output miso_host_out, miso_host_oe, sclk_host_out, sclk_host_oe, sda_host_out, sda_host_oe
    );
endinterface

// ===== src/rshp_host_end.sv
// Far party: drives reset and straps, masters SPI or I2C, answers as SPI EEPROM.
// Assumes the device end on the same pins interface.
`timescale 1ns/1ps
module rshp_host_end #(
    parameter int HALF_CYC = rshp_pkg::HOST_HALF_CYC,
    parameter int SETUP_CYC = rshp_pkg::HOST_SETUP_CYC,
    parameter int HOLD_CYC = rshp_pkg::STRAP_HOLD_CYC
) (
    input wire logic clock,
    input wire logic srst,
    rshp_pins_if.host pins,
    input wire logic reset_request,
    input wire logic strap_test,
    input wire logic [2:0] strap_ac,
    input wire logic [1:0] strap_mode,
    input wire logic spi_start,
    input wire logic [7:0] spi_tx_byte,
    input wire logic scl_pull,
    input wire logic sda_pull,
    output logic [7:0] spi_rx_byte,
    output logic spi_done,
    output logic spi_busy
);
    typedef struct packed {
        logic rst_n;
        logic strap;
        logic [7:0] hold;
        rshp_pkg::rshp_mode_type mode;
        rshp_pkg::rshp_hst_type state;
        logic [7:0] div;
        logic [3:0] bitc;
        logic [7:0] tx, rx, rx_out;
        logic ssn, sclk, mosi, done, busy;
        logic [1:0] miso_s;
        logic [2:0] ck_s;
        logic [1:0] ss_s;
        logic [11:0] rcount;
        logic miso_q;
        logic [3:0] io_out;
        logic ssn_out, ssn_oe, miso_out, miso_oe, sclk_out, sclk_oe, sda_out, sda_oe;
    } rshp_host_state_type;

    rshp_host_state_type q, n;

    always_comb begin
        logic [11:0] idx;
        logic [7:0] bytev;
        logic spi, mst, i2c;
        idx = q.rcount - 12'(rshp_pkg::EE_HEADER_BITS);
        bytev = idx[10:3];
        spi = !q.strap && (q.mode == rshp_pkg::RSHP_SPI_SLAVE);
        mst = !q.strap && (q.mode == rshp_pkg::RSHP_SPI_MASTER);
        i2c = !q.strap && !q.mode[1];
        n = q;
        n.done = 1'b0;
        n.miso_s = {q.miso_s[0], pins.miso};
        n.ck_s = {q.ck_s[1:0], pins.sclk};
        n.ss_s = {q.ss_s[0], pins.serial_select_n};
        if (reset_request) begin
            n.rst_n = 1'b0;
            n.strap = 1'b1;
            n.hold = 8'h00;
            n.mode = rshp_pkg::rshp_mode_type'(strap_mode);
            n.state = rshp_pkg::H_IDLE;
            n.ssn = 1'b1;
            n.sclk = 1'b0;
            n.busy = 1'b0;
        end else begin
            n.rst_n = 1'b1;
            if (q.strap) begin
                if (q.hold == 8'(HOLD_CYC - 1)) begin // R4
                    n.strap = 1'b0;
                end else begin
                    n.hold = q.hold + 8'h01;
                end
            end
        end
        if (spi && !reset_request) begin
            unique case (q.state)
                rshp_pkg::H_IDLE: begin
                    if (spi_start) begin
                        n.ssn = 1'b0; // R6
                        n.tx = spi_tx_byte;
                        n.mosi = spi_tx_byte[7];
                        n.div = 8'h00;
                        n.busy = 1'b1;
                        n.state = rshp_pkg::H_SETUP;
                    end
                end
                rshp_pkg::H_SETUP: begin
                    n.div = q.div + 8'h01;
                    if (q.div == 8'(SETUP_CYC - 1)) begin
                        n.div = 8'h00;
                        n.bitc = 4'h0;
                        n.state = rshp_pkg::H_RUN;
                    end
                end
                rshp_pkg::H_RUN: begin
                    n.div = q.div + 8'h01;
                    if (q.div == 8'(HALF_CYC - 1)) begin
                        n.div = 8'h00;
                        n.sclk = ~q.sclk; // R11
                        if (!q.sclk) begin
                            n.rx = {q.rx[6:0], q.miso_s[1]};
                        end else begin
                            n.bitc = q.bitc + 4'h1;
                            n.tx = {q.tx[6:0], 1'b0};
                            n.mosi = q.tx[6];
                            if (q.bitc == 4'h7) begin
                                n.state = rshp_pkg::H_END;
                            end
                        end
                    end
                end
                rshp_pkg::H_END: begin
                    n.ssn = 1'b1;
                    n.rx_out = q.rx;
                    n.done = 1'b1;
                    n.busy = 1'b0;
                    n.state = rshp_pkg::H_IDLE;
                end
            endcase
        end
        // Memory responder while the device masters the bus
        if (q.ss_s[1]) begin
            n.rcount = 12'h000;
        end else if (q.ck_s[1] && !q.ck_s[2]) begin
            n.rcount = q.rcount + 12'h001;
        end else if (!q.ck_s[1] && q.ck_s[2] && q.rcount >= 12'(rshp_pkg::EE_HEADER_BITS)) begin
            n.miso_q = bytev[3'h7 - idx[2:0]];
        end
        n.io_out = {strap_test, strap_ac};
        n.ssn_out = q.strap ? strap_mode[0] : q.ssn;
        n.ssn_oe = q.strap || !mst; // R8
        n.miso_out = q.strap ? strap_mode[1] : q.miso_q;
        // High strap left to the pull-up: slave read data may start in the hold
        n.miso_oe = (q.strap && !strap_mode[1]) || (mst && !q.ss_s[1]);
        n.sclk_out = spi ? q.sclk : 1'b0;
        n.sclk_oe = spi || (i2c && scl_pull); // R13
        n.sda_out = spi ? q.mosi : 1'b0;
        n.sda_oe = spi || (i2c && sda_pull); // R14
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign pins.global_reset_n = q.rst_n;
    assign pins.io_host_out = q.io_out;
    assign pins.io_host_oe = {4{q.strap}};
    assign pins.ssn_host_out = q.ssn_out;
    assign pins.ssn_host_oe = q.ssn_oe;
    assign pins.miso_host_out = q.miso_out;
    assign pins.miso_host_oe = q.miso_oe;
    assign pins.sclk_host_out = q.sclk_out;
    assign pins.sclk_host_oe = q.sclk_oe;
    assign pins.sda_host_out = q.sda_out;
    assign pins.sda_host_oe = q.sda_oe;
    assign spi_rx_byte = q.rx_out;
    assign spi_done = q.done;
    assign spi_busy = q.busy;
endmodule // rshp_host_end

// ===== src/rshp_device_end.sv
// Device end: strap capture at reset release, shared io pins, SPI/I2C pin roles.
// Assumes the host end on the same pins; SPI slave logic runs on the pin clock.
// Notes on behaviour
// R1 - After reset, three straps become general io
// R2 - Test strap becomes fourth io, live and latched
// R3 - Test strap high at release enters test
// R4 - Host normally holds test strap low
// R5 - Select and serial-out pins sampled as mode
// R6 - Host holds select low during register access
// R7 - Master mode: drive select, then release it
// R8 - Select line never left floating
// R9 - Slave mode: read data driven on serial-out
// R10 - Master mode: memory data taken from serial-out
// R11 - Slave mode: host supplies the serial clock
// R12 - Master mode: device drives the serial clock
// R13 - I2C mode: host supplies the clock
// R14 - I2C data pin is shared open-drain
// R15 - All strap levels captured into status
// R16 - Mode codes: two I2C addresses, SPI slave, SPI master
// R17 - Straps fixed until next reset release
`timescale 1ns/1ps
module rshp_device_end #(
    parameter int AUTOCFG_BYTES = 4,
    parameter int HALF_CYC = rshp_pkg::MST_HALF_CYC
) (
    input wire logic clock,
    input wire logic srst,
    rshp_pins_if.device pins,
    input wire logic [3:0] io_config_reg_a,
    input wire logic [3:0] io_config_reg_b,
    input wire logic [3:0] io_status_clear,
    input wire logic i2c_sda_pull,
    output logic [7:0] io_status_reg,
    output logic [5:0] strap_capture_status,
    output logic [2:0] autoconfig_select,
    output logic factory_test,
    output rshp_pkg::rshp_mode_type host_mode,
    output logic [6:0] i2c_address,
    output logic operating,
    output logic autoconfig_busy,
    output logic autoconfig_done,
    output logic [7:0] eeprom_byte,
    output logic eeprom_valid,
    output logic [7:0] slave_rx_byte,
    output logic slave_rx_valid,
    output logic i2c_scl_level,
    output logic i2c_sda_level
);
    typedef struct packed {
        logic [2:0] rst_sync;
        logic [3:0] io_s1, io_s2;
        logic [3:0] pin_s1, pin_s2;
        logic run;
        logic [5:0] straps;
        rshp_pkg::rshp_mode_type mode;
        logic [6:0] i2c_addr;
        logic [3:0] io_out, io_oe, io_rt, io_lat;
        rshp_pkg::rshp_mst_type mstate;
        logic [7:0] div;
        logic [4:0] bits;
        logic [15:0] shift;
        logic [7:0] nbytes;
        logic sclk, ssn_out, ctl_oe, mosi;
        logic [7:0] ee_byte;
        logic ee_valid, busy, done;
        logic [2:0] tog;
        logic [7:0] rx;
        logic rx_valid, miso_oe, sda_oe, scl_lvl, sda_lvl;
    } rshp_dev_state_type;

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] shreg;
        logic [7:0] rx_byte;
        logic [7:0] tx;
        logic rx_toggle;
    } rshp_slv_state_type;

    rshp_dev_state_type q, n;
    rshp_slv_state_type sl_q, sl_d;
    logic [7:0] io_cfg;
    logic [3:0] io_oe_w, io_out_w;

    assign io_cfg = {io_config_reg_b, io_config_reg_a};

    // Per-pin io decode
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_io
            assign io_oe_w[gi] = (io_cfg[2*gi+1 -: 2] == rshp_pkg::IO_CFG_OUT_LOW) ||
                                 (io_cfg[2*gi+1 -: 2] == rshp_pkg::IO_CFG_OUT_HIGH); // R1 R2
            assign io_out_w[gi] = (io_cfg[2*gi+1 -: 2] == rshp_pkg::IO_CFG_OUT_HIGH);
        end
    endgenerate

    always_comb begin
        logic tick, master;
        tick = (q.div == 8'(HALF_CYC - 1));
        master = (q.mode == rshp_pkg::RSHP_SPI_MASTER);
        n = q;
        n.rst_sync = {q.rst_sync[1:0], pins.global_reset_n};
        n.io_s1 = pins.io;
        n.io_s2 = q.io_s1;
        n.pin_s1 = {pins.serial_select_n, pins.miso, pins.sclk, pins.sda};
        n.pin_s2 = q.pin_s1;
        n.tog = {q.tog[1:0], sl_q.rx_toggle};
        n.rx_valid = 1'b0;
        n.ee_valid = 1'b0;
        n.scl_lvl = q.pin_s2[1];
        n.sda_lvl = q.pin_s2[0];
        if (q.tog[2] != q.tog[1]) begin
            n.rx = sl_q.rx_byte;
            n.rx_valid = 1'b1;
        end
        if (!q.rst_sync[1]) begin
            // Pins stay released so the straps read cleanly
            n.run = 1'b0;
            n.io_oe = 4'h0;
            n.ctl_oe = 1'b0;
            n.miso_oe = 1'b0;
            n.sda_oe = 1'b0;
            n.ssn_out = 1'b1;
            n.sclk = 1'b0;
            n.mosi = 1'b0;
            n.busy = 1'b0;
            n.done = 1'b0;
            n.mstate = rshp_pkg::M_IDLE;
        end else if (!q.rst_sync[2]) begin
            // Release edge: straps were synchronised alongside the reset
            n.run = 1'b1;
            n.straps = {q.io_s2, q.pin_s2[2], q.pin_s2[3]}; // R15 R3 R5
            n.mode = rshp_pkg::rshp_mode_type'({q.pin_s2[2], q.pin_s2[3]}); // R5 R17
            n.i2c_addr = q.pin_s2[3] ? rshp_pkg::I2C_ADDR_B : rshp_pkg::I2C_ADDR_A; // R16
            if ({q.pin_s2[2], q.pin_s2[3]} == 2'h3 &&
                !(q.io_s2[3] && q.io_s2[2:0] == rshp_pkg::AC_NO_AUTOCFG)) begin
                n.mstate = rshp_pkg::M_SEND;
                n.ssn_out = 1'b0; // R7
                n.ctl_oe = 1'b1;
                n.sda_oe = 1'b1;
                n.shift = {rshp_pkg::EE_READ_CMD, rshp_pkg::EE_START_ADDR};
                n.mosi = rshp_pkg::EE_READ_CMD[7];
                n.bits = 5'h00;
                n.nbytes = 8'h00;
                n.div = 8'h00;
                n.busy = 1'b1;
            end else begin
                n.done = 1'b1;
            end
        end else begin
            n.io_oe = io_oe_w; // R1 R2
            n.io_out = io_out_w;
            n.io_rt = q.io_s2;
            n.io_lat = (q.io_lat & ~io_status_clear) | q.io_s2; // R2
            n.miso_oe = (q.mode == rshp_pkg::RSHP_SPI_SLAVE) && !q.pin_s2[3]; // R9
            if (!q.mode[1]) begin
                n.sda_oe = i2c_sda_pull; // R14
            end
            unique case (q.mstate)
                rshp_pkg::M_IDLE: begin
                end
                rshp_pkg::M_SEND, rshp_pkg::M_READ: begin
                    n.div = tick ? 8'h00 : q.div + 8'h01;
                    if (tick && !q.sclk) begin
                        n.sclk = 1'b1; // R12
                        n.bits = q.bits + 5'h01;
                        if (q.mstate == rshp_pkg::M_READ) begin
                            n.shift = {q.shift[14:0], q.pin_s2[2]}; // R10
                            if (q.bits == 5'h07) begin
                                n.ee_byte = {q.shift[6:0], q.pin_s2[2]};
                                n.ee_valid = 1'b1;
                                n.bits = 5'h00;
                                n.nbytes = q.nbytes + 8'h01;
                                if (q.nbytes == 8'(AUTOCFG_BYTES - 1)) begin
                                    n.mstate = rshp_pkg::M_FINISH;
                                end
                            end
                        end
                    end else if (tick) begin
                        n.sclk = 1'b0; // R12
                        if (q.mstate == rshp_pkg::M_SEND) begin
                            if (q.bits == 5'(rshp_pkg::EE_HEADER_BITS)) begin
                                n.mstate = rshp_pkg::M_READ;
                                n.bits = 5'h00;
                            end else begin
                                n.shift = {q.shift[14:0], 1'b0};
                                n.mosi = q.shift[14];
                            end
                        end
                    end
                end
                rshp_pkg::M_FINISH: begin
                    n.div = q.div + 8'h01;
                    if (tick) begin
                        n.sclk = 1'b0;
                        n.ssn_out = 1'b1;
                        n.mosi = 1'b0;
                        n.mstate = rshp_pkg::M_DONE;
                    end
                end
                rshp_pkg::M_DONE: begin
                    n.ctl_oe = 1'b0; // R7
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end
                default: begin
                    n.mstate = rshp_pkg::M_IDLE;
                end
            endcase
            if (master) begin
                n.sda_oe = n.ctl_oe;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Slave shifter on the host's clock; select high rewinds the bit count
    always_comb begin
        sl_d = sl_q;
        sl_d.cnt = sl_q.cnt + 3'h1;
        sl_d.shreg = {sl_q.shreg[6:0], pins.sda};
        sl_d.tx = {sl_q.tx[6:0], 1'b0};
        if (sl_q.cnt == 3'h7) begin
            // Echo: the byte just written is the next one read back
            sl_d.rx_byte = {sl_q.shreg[6:0], pins.sda};
            sl_d.tx = {sl_q.shreg[6:0], pins.sda}; // R9
            sl_d.rx_toggle = ~sl_q.rx_toggle;
        end
    end

    always_ff @(posedge pins.sclk or posedge pins.serial_select_n or negedge pins.global_reset_n) begin
        if (!pins.global_reset_n) begin
            sl_q <= '0;
        end else if (pins.serial_select_n) begin
            sl_q.cnt <= 3'h0; // R6
        end else begin
            sl_q <= sl_d;
        end
    end

    assign pins.io_dev_out = q.io_out;
    assign pins.io_dev_oe = q.io_oe;
    assign pins.ssn_dev_out = q.ssn_out;
    assign pins.ssn_dev_oe = q.ctl_oe;
    assign pins.miso_dev_out = sl_q.tx[7];
    assign pins.miso_dev_oe = q.miso_oe;
    assign pins.sclk_dev_out = q.sclk;
    assign pins.sclk_dev_oe = q.ctl_oe;
    assign pins.sda_dev_out = q.mosi;
    assign pins.sda_dev_oe = q.sda_oe;
    assign io_status_reg = {q.io_lat, q.io_rt};
    assign strap_capture_status = q.straps;
    assign autoconfig_select = q.straps[rshp_pkg::STRAP_AC_LSB +: 3];
    assign factory_test = q.straps[rshp_pkg::STRAP_TEST_BIT]; // R3
    assign host_mode = q.mode;
    assign i2c_address = q.i2c_addr;
    assign operating = q.run;
    assign autoconfig_busy = q.busy;
    assign autoconfig_done = q.done;
    assign eeprom_byte = q.ee_byte;
    assign eeprom_valid = q.ee_valid;
    assign slave_rx_byte = q.rx;
    assign slave_rx_valid = q.rx_valid;
    assign i2c_scl_level = q.scl_lvl;
    assign i2c_sda_level = q.sda_lvl;
endmodule // rshp_device_end

// ===== bench/rshp_props.sv
// Checker on the shared pins between device end and host end.
// Assumes pins signals sampled on the device clock; no bind, instanced by the bench.
`timescale 1ns/1ps
module rshp_props (
    input wire logic clock,
    input wire logic srst,
    input wire logic global_reset_n,
    input wire logic [3:0] io_dev_oe,
    input wire logic ssn_dev_oe,
    input wire logic serial_select_n,
    input wire logic miso_dev_oe,
    input wire logic miso_host_oe,
    input wire logic sclk,
    input wire logic sclk_dev_oe,
    input wire logic sclk_host_oe,
    input wire logic sda_dev_oe,
    input wire logic sda
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // Four cycles covers the two-flop sync plus the output flop
    reset_oe_off_a: assert property (!global_reset_n [*4] |->
        !(ssn_dev_oe | sclk_dev_oe | miso_dev_oe | sda_dev_oe | (|io_dev_oe)))
        else $error("device drives a pin while held in reset");
    sclk_rise_select_a: assert property ($rose(sclk) && ssn_dev_oe |->
        !serial_select_n && sclk_dev_oe)
        else $error("memory clock rises without select low");
    sclk_high_hold_a: assert property ($rose(sclk) && ssn_dev_oe |-> sclk [*8])
        else $error("memory clock high phase too short");
    sclk_no_fight_a: assert property (!(sclk_dev_oe && sclk_host_oe))
        else $error("both ends drive the serial clock");
    miso_quiet_a: assert property (serial_select_n [*4] |-> !miso_dev_oe)
        else $error("serial-out driven while not selected");
    miso_no_fight_a: assert property (!(miso_dev_oe && miso_host_oe))
        else $error("both ends drive serial-out");
    select_first_bit_a: assert property ($rose(ssn_dev_oe) |-> !serial_select_n && !sda)
        else $error("memory access does not start with select low and bit zero");
    select_release_a: assert property ($fell(ssn_dev_oe) && global_reset_n |->
        !sclk_dev_oe && serial_select_n && $past(serial_select_n))
        else $error("clock still driven after select released");

    cover property ($rose(ssn_dev_oe));
    cover property ($rose(miso_dev_oe));
    cover property ($fell(sda) && sda_dev_oe && !ssn_dev_oe);
endmodule // rshp_props

// ===== bench/reset_strap_host_pin_roles_tb.sv
// Bench joining device end and host end over the pins interface.
// Assumes both ends on one 40 MHz clock; the serial clock is made by the ends.
`timescale 1ns/1ps
module reset_strap_host_pin_roles_tb;
    logic clock = 1'b0, srst = 1'b1, reset_request = 1'b1, strap_test = 1'b0;
    logic spi_start = 1'b0, scl_pull = 1'b0, sda_pull = 1'b0, i2c_sda_pull = 1'b0;
    logic [2:0] strap_ac = 3'h0;
    logic [1:0] strap_mode = 2'h0;
    logic [7:0] spi_tx_byte = 8'h00;
    logic [3:0] io_config_reg_a = 4'h0, io_config_reg_b = 4'h0, io_status_clear = 4'h0;
    logic [7:0] spi_rx_byte, io_status_reg, eeprom_byte, slave_rx_byte;
    logic spi_done, spi_busy, factory_test, operating, autoconfig_busy, autoconfig_done;
    logic eeprom_valid, slave_rx_valid, i2c_scl_level, i2c_sda_level;
    logic [5:0] strap_capture_status;
    logic [2:0] autoconfig_select;
    logic [6:0] i2c_address;
    rshp_pkg::rshp_mode_type host_mode;
    int error_cnt = 0, comparisons = 0;

    rshp_pins_if pins();
    rshp_host_end rshp_host_end_inst (.clock, .srst, .pins(pins), .reset_request, .strap_test,
        .strap_ac, .strap_mode, .spi_start, .spi_tx_byte, .scl_pull, .sda_pull, .spi_rx_byte,
        .spi_done, .spi_busy);
    rshp_device_end rshp_device_end_inst (.clock, .srst, .pins(pins), .io_config_reg_a,
        .io_config_reg_b, .io_status_clear, .i2c_sda_pull, .io_status_reg, .strap_capture_status,
        .autoconfig_select, .factory_test, .host_mode, .i2c_address, .operating, .autoconfig_busy,
        .autoconfig_done, .eeprom_byte, .eeprom_valid, .slave_rx_byte, .slave_rx_valid,
        .i2c_scl_level, .i2c_sda_level);
    rshp_props rshp_props_inst (.clock, .srst, .global_reset_n(pins.global_reset_n),
        .io_dev_oe(pins.io_dev_oe), .ssn_dev_oe(pins.ssn_dev_oe),
        .serial_select_n(pins.serial_select_n), .miso_dev_oe(pins.miso_dev_oe),
        .miso_host_oe(pins.miso_host_oe), .sclk(pins.sclk), .sclk_dev_oe(pins.sclk_dev_oe),
        .sclk_host_oe(pins.sclk_host_oe), .sda_dev_oe(pins.sda_dev_oe), .sda(pins.sda));

    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Inputs always move 2 ns after the edge, clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic do_reset(input logic t, input logic [2:0] ac, input logic [1:0] m);
        strap_test = t;
        strap_ac = ac;
        strap_mode = m;
        reset_request = 1'b1;
        step(10);
        reset_request = 1'b0;
        step(12);
        check(strap_capture_status, {t, ac, m});
        check(host_mode, m);
        check(factory_test, t);
        check(autoconfig_select, ac);
        check(operating, 1'b1);
        if (!m[1]) begin
            check(i2c_address, m[0] ? rshp_pkg::I2C_ADDR_B : rshp_pkg::I2C_ADDR_A);
        end
    endtask

    task automatic spi_xfer(input logic [7:0] tx, input logic [7:0] exp_rx);
        int n;
        spi_tx_byte = tx;
        spi_start = 1'b1;
        step(1);
        spi_start = 1'b0;
        for (n = 0; n < 400 && spi_done !== 1'b1; n++) step(1);
        check({spi_done, spi_busy}, 2'h2);
        check(spi_rx_byte, exp_rx);
        step(8);
        check(slave_rx_byte, tx);
    endtask

    initial begin
        int n;
        int k;
        step(6);
        srst = 1'b0;
        // Test strap kept low here, as boards normally do
        do_reset(1'b0, 3'h5, rshp_pkg::RSHP_SPI_SLAVE);
        spi_xfer(8'ha5, 8'h00);
        spi_xfer(8'h3c, 8'ha5);
        io_config_reg_a = 4'h1;
        io_config_reg_b = 4'h8;
        step(6);
        check(pins.io, 4'he);
        io_status_clear = 4'hf;
        step(1);
        io_status_clear = 4'h0;
        step(2);
        check(io_status_reg, 8'hee);
        io_config_reg_b = 4'h4;
        step(6);
        io_status_clear = 4'hf;
        step(1);
        io_status_clear = 4'h0;
        step(2);
        check(io_status_reg, 8'h66);
        check(strap_capture_status, 6'h16);
        check(host_mode, rshp_pkg::RSHP_SPI_SLAVE);
        io_config_reg_a = 4'h0;
        io_config_reg_b = 4'h0;
        do_reset(1'b0, 3'h2, rshp_pkg::RSHP_SPI_MASTER);
        check(pins.sclk_dev_oe, 1'b1);
        check(autoconfig_busy, 1'b1);
        k = 0;
        for (n = 0; n < 3000 && autoconfig_done !== 1'b1; n++) begin
            if (eeprom_valid === 1'b1) begin
                check(eeprom_byte, 16'(k));
                k++;
            end
            step(1);
        end
        check(16'(k), 16'h0004);
        check(autoconfig_done, 1'b1);
        check({pins.ssn_dev_oe, pins.sclk_dev_oe}, 2'h0);
        check(autoconfig_busy, 1'b0);
        check(pins.serial_select_n, 1'b1);
        // Test with code 3 starts normally, so it shares the plain I2C checks
        for (k = 0; k < 2; k++) begin
            do_reset(k == 0, k == 0 ? 3'h3 : 3'h0, 2'(k));
            scl_pull = 1'b1;
            step(4);
            check(i2c_scl_level, 1'b0);
            scl_pull = 1'b0;
            i2c_sda_pull = 1'b1;
            step(3);
            check(pins.sda, 1'b0);
            i2c_sda_pull = 1'b0;
            sda_pull = 1'b1;
            step(4);
            check(i2c_sda_level, 1'b0);
            sda_pull = 1'b0;
            step(4);
            check(i2c_sda_level, 1'b1);
        end
        complete_run();
    end

    // Whole run is near 1100 cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule // reset_strap_host_pin_roles_tb
